// [logic/ile_params.svh]
/*
 Constants of the interrupt latch and enable unit: SFR addresses, field masks,
 reset values, and the register map of the controller end.
 Assumes it is included by bare name after the package.
*/
`ifndef ILE_PARAMS_SVH
`define ILE_PARAMS_SVH

// ----------------------------------------
// Sources and fields
// ----------------------------------------
`define ILE_NSRC        24
`define ILE_LATCH_MASK  24'hfffffc
`define ILE_NMI_MASK    24'h00000c
`define ILE_EF_MASK     24'hfffff0
`define ILE_PROT_BITS   8'h0c
`define ILE_IMF_BIT     0
`define ILE_LATCH_RST   24'h000000
`define ILE_ENAB_RST    24'h000000
`define ILE_STK_DEPTH   8

// ----------------------------------------
// SFR addresses
// ----------------------------------------
`define ILE_A_LAT_LO    8'h3c
`define ILE_A_LAT_HI    8'h3d
`define ILE_A_LAT_TOP   8'h2e
`define ILE_A_EN_LO     8'h3a
`define ILE_A_EN_HI     8'h3b
`define ILE_A_EN_TOP    8'h2c

// ----------------------------------------
// Controller end, APB map and fields
// ----------------------------------------
`define ILE_R_CTRL      12'h000
`define ILE_R_CMD       12'h004
`define ILE_R_STATUS    12'h008
`define ILE_R_RDATA     12'h00c
`define ILE_R_ISTAT     12'h010
`define ILE_R_IMASK     12'h014
`define ILE_OP_WR       3'h0
`define ILE_OP_RD       3'h1
`define ILE_OP_EI       3'h2
`define ILE_OP_DI       3'h3
`define ILE_OP_RET      3'h4
`define ILE_EV_ACC      0
`define ILE_EV_DONE     1

`endif

// [logic/ile_pkg.sv]
/*
 Types of the interrupt latch and enable unit.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ile_pkg;
	typedef logic [23:0] ile_word_t;
	typedef enum logic [5:0] {
		ILE_IDLE = 6'h01,
		ILE_DIS  = 6'h02,
		ILE_ACC  = 6'h04,
		ILE_WAIT = 6'h08,
		ILE_ENA  = 6'h10,
		ILE_ACK  = 6'h20
	} ile_state_t;
endpackage : ile_pkg

// [logic/ile_sfr_if.sv]
/*
 Special-function register path and interrupt acceptance handshake
 between the core end and the latch and enable unit.
 Assumes both ends run on one clock.
*/
`timescale 1ns/1ps
interface ile_sfr_if;
	logic [7:0] sfrAddr;
	logic       sfrWr;
	logic       sfrRd;
	logic [7:0] sfrWdata;
	logic [7:0] sfrRdata;
	logic       sfrRvalid;
	logic       intReq;
	logic [4:0] intVec;
	logic       intAck;
	logic       retPulse;
	logic       eiPulse;
	logic       diPulse;

	modport dev (
		input  sfrAddr, sfrWr, sfrRd, sfrWdata, intAck, retPulse, eiPulse, diPulse,
		output sfrRdata, sfrRvalid, intReq, intVec
	);
	modport cpu (
		output sfrAddr, sfrWr, sfrRd, sfrWdata, intAck, retPulse, eiPulse, diPulse,
		input  sfrRdata, sfrRvalid, intReq, intVec
	);
endinterface : ile_sfr_if

// [logic/ile_device.sv]
/*
 Interrupt latch and enable unit: request latches, per-source enables,
 master enable flag with its acceptance stack, fixed priority pick.
 Assumes the core end keeps to the clearing and ordering discipline and
 that request pulses are synchronous to ref_clk.
*/
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "ile_params.svh"

// Function
// R1: Latches readable/writable at three SFR addresses
// R2: Writing zero clears one latch alone
// R3: Software never clears protected latches
// R4: Software clears latches by plain load only
// R5: Writing one to a latch is ignored
// R6: Reads return current latch state
// R7: Outside handlers, master off around edits
// R8: In nesting handlers, edit before re-enable
// R9: Non-maskable requests ignore enable register
// R10: Enable register at three read/write addresses
// R11: Master flag zero blocks maskable requests
// R12: Master one: accept only enabled sources
// R13: Acceptance stacks master flag, then clears
// R14: Return reloads master flag from stack
// R15: Master flag is enable bit 0
// R16: Master flag zero after reset
// R17: One request presented, fixed priority
module ile_device
	import ile_pkg::*;
(
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	// Hardware request events, one-cycle pulses
	input  wire logic [`ILE_NSRC-1:0] srcReq,
	// Core side
	ile_sfr_if.dev                    sfr,
	// Observation
	output logic                      imfOut,
	output logic [`ILE_NSRC-1:0]      latchOut
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	ile_word_t  latch_ff;
	ile_word_t  nxt_latch;
	ile_word_t  enab_ff;
	ile_word_t  nxt_enab;
	logic       stk_ff [`ILE_STK_DEPTH];
	logic [3:0] sp_ff;
	logic [7:0] rdata_ff;
	logic       rvalid_ff;
	logic       intReq_ff;
	logic [4:0] intVec_ff;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic [2:0] latLane;
	logic [2:0] enLane;
	ile_word_t  wrWord;
	ile_word_t  latLaneMask;
	ile_word_t  enLaneMask;
	ile_word_t  elig;
	ile_word_t  ackMask;
	logic       pickValid;
	logic [4:0] pickIdx;
	logic       accept;
	logic [3:0] popIdx;

	always_comb begin
		latLane[0] = sfr.sfrAddr == `ILE_A_LAT_LO; // see R1
		latLane[1] = sfr.sfrAddr == `ILE_A_LAT_HI;
		latLane[2] = sfr.sfrAddr == `ILE_A_LAT_TOP;
		enLane[0]  = sfr.sfrAddr == `ILE_A_EN_LO; // see R10
		enLane[1]  = sfr.sfrAddr == `ILE_A_EN_HI;
		enLane[2]  = sfr.sfrAddr == `ILE_A_EN_TOP;
		wrWord     = {3{sfr.sfrWdata}};
		latLaneMask = {{8{latLane[2]}}, {8{latLane[1]}}, {8{latLane[0]}}};
		enLaneMask  = {{8{enLane[2]}}, {8{enLane[1]}}, {8{enLane[0]}}};
	end

	// ----------------------------------------
	// Priority pick
	// ----------------------------------------
	// Non-maskable bits pass unconditionally; maskable ones need both flags
	always_comb begin
		elig = latch_ff & `ILE_LATCH_MASK & (`ILE_NMI_MASK |
			({`ILE_NSRC{enab_ff[`ILE_IMF_BIT]}} & enab_ff & `ILE_EF_MASK)); // see R9 see R11 see R12
		pickValid = 1'b0;
		pickIdx   = 5'h00;
		for (int i = `ILE_NSRC - 1; i >= 0; i--) begin
			if (elig[i]) begin // see R17
				pickValid = 1'b1;
				pickIdx   = 5'(i);
			end
		end
	end

	// An acknowledge counts only if the presented vector is still the current pick
	assign accept = sfr.intAck && intReq_ff && pickValid && (pickIdx == intVec_ff);
	assign popIdx = (sp_ff == 4'h0) ? 4'h0 : sp_ff - 4'h1;

	always_comb begin
		ackMask = '0;
		if (accept) begin
			ackMask[intVec_ff] = 1'b1;
		end
	end

	// ----------------------------------------
	// Request latches
	// ----------------------------------------
	// A write only ANDs, so ones are ignored; a new request wins over any clear
	always_comb begin
		nxt_latch = latch_ff & ~ackMask;
		if (sfr.sfrWr) begin
			nxt_latch = nxt_latch & (wrWord | ~latLaneMask); // see R2 see R5
		end
		nxt_latch = (nxt_latch | srcReq) & `ILE_LATCH_MASK;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			latch_ff <= `ILE_LATCH_RST;
		end else begin
			latch_ff <= nxt_latch;
		end
	end

	// ----------------------------------------
	// Enable register and master flag
	// ----------------------------------------
	always_comb begin
		nxt_enab = enab_ff;
		if (sfr.sfrWr) begin
			nxt_enab = (enab_ff & ~enLaneMask) | (wrWord & enLaneMask); // see R10
		end
		if (sfr.diPulse) begin
			nxt_enab[`ILE_IMF_BIT] = 1'b0; // see R15
		end
		if (sfr.eiPulse) begin
			nxt_enab[`ILE_IMF_BIT] = 1'b1; // see R15
		end
		if (sfr.retPulse) begin
			nxt_enab[`ILE_IMF_BIT] = stk_ff[popIdx[2:0]]; // see R14
		end
		if (accept) begin
			nxt_enab[`ILE_IMF_BIT] = 1'b0; // see R13
		end
		nxt_enab = nxt_enab & (`ILE_EF_MASK | 24'h000001);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			enab_ff <= `ILE_ENAB_RST; // see R16
		end else begin
			enab_ff <= nxt_enab;
		end
	end

	// ----------------------------------------
	// Master flag stack
	// ----------------------------------------
	// Overflow keeps the pointer at the top and overwrites the last entry
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sp_ff <= 4'h0;
			for (int i = 0; i < `ILE_STK_DEPTH; i++) begin
				stk_ff[i] <= 1'b0;
			end
		end else if (accept) begin
			if (sp_ff == 4'(`ILE_STK_DEPTH)) begin
				stk_ff[`ILE_STK_DEPTH-1] <= enab_ff[`ILE_IMF_BIT]; // see R13
			end else begin
				stk_ff[sp_ff[2:0]] <= enab_ff[`ILE_IMF_BIT]; // see R13
				sp_ff              <= sp_ff + 4'h1;
			end
		end else if (sfr.retPulse && sp_ff != 4'h0) begin
			sp_ff <= sp_ff - 4'h1; // see R14
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_ff  <= 8'h00;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= sfr.sfrRd;
			if (sfr.sfrRd) begin
				unique case (1'b1)
					latLane[0]: rdata_ff <= latch_ff[7:0]; // see R6
					latLane[1]: rdata_ff <= latch_ff[15:8];
					latLane[2]: rdata_ff <= latch_ff[23:16];
					enLane[0]:  rdata_ff <= enab_ff[7:0];
					enLane[1]:  rdata_ff <= enab_ff[15:8];
					enLane[2]:  rdata_ff <= enab_ff[23:16];
					default:    rdata_ff <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Request presentation
	// ----------------------------------------
	// Held off for a cycle after an acknowledge, a write, a disable or a return, so a stale vector is never shown
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			intReq_ff <= 1'b0;
			intVec_ff <= 5'h00;
		end else begin
			intReq_ff <= pickValid && !sfr.intAck && !sfr.sfrWr && !sfr.diPulse && !sfr.retPulse; // see R17
			intVec_ff <= pickIdx;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign sfr.sfrRdata  = rdata_ff;
	assign sfr.sfrRvalid = rvalid_ff;
	assign sfr.intReq    = intReq_ff;
	assign sfr.intVec    = intVec_ff;
	assign imfOut        = enab_ff[`ILE_IMF_BIT];
	assign latchOut      = latch_ff;

endmodule : ile_device

// [logic/ile_cpu_end.sv]
/*
 Core end: takes orders from software over APB, drives SFR accesses,
 master flag instructions and interrupt acceptance toward the unit.
 Assumes an APB master on ref_clk and the unit on the other modport.
*/
`timescale 1ns/1ps
`include "ile_params.svh"

module ile_cpu_end
	import ile_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Interrupt to software
	output logic             irq,
	// Unit side
	ile_sfr_if.cpu           sfr
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	ile_state_t state_ff;
	logic [1:0]  ctrl_ff;
	logic [2:0]  op_ff;
	logic [7:0]  addr_ff;
	logic [7:0]  wdat_ff;
	logic [7:0]  rd_ff;
	logic [4:0]  vec_ff;
	logic [1:0]  stat_ff;
	logic [1:0]  mask_ff;
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic        irq_ff;
	logic [7:0]  oAddr_ff;
	logic [7:0]  oWd_ff;
	logic        oWr_ff, oRd_ff, oAck_ff, oRet_ff, oEi_ff, oDi_ff;
	logic        apbDo, cmdGo, mapped, isLatch, doneEv, accEv;

	assign apbDo  = psel && penable && pready_ff;
	assign cmdGo  = apbDo && pwrite && paddr == `ILE_R_CMD && state_ff == ILE_IDLE;
	assign mapped = paddr inside {`ILE_R_CTRL, `ILE_R_CMD, `ILE_R_STATUS, `ILE_R_RDATA, `ILE_R_ISTAT, `ILE_R_IMASK};
	assign isLatch = addr_ff inside {`ILE_A_LAT_LO, `ILE_A_LAT_HI, `ILE_A_LAT_TOP, `ILE_A_EN_HI, `ILE_A_EN_TOP};
	assign accEv  = state_ff == ILE_ACK;
	assign doneEv = (state_ff == ILE_WAIT && sfr.sfrRvalid) || (state_ff == ILE_ENA)
		|| (state_ff == ILE_ACC && op_ff != `ILE_OP_RD && !(ctrl_ff[1] && isLatch));

	// ----------------------------------------
	// APB slave, one wait state
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end else if (psel && penable && !pready_ff) begin
			pready_ff  <= 1'b1;
			pslverr_ff <= !mapped;
			unique case (paddr)
				`ILE_R_CTRL:   prdata_ff <= {30'h0, ctrl_ff};
				`ILE_R_STATUS: prdata_ff <= {19'h0, vec_ff, 7'h0, state_ff != ILE_IDLE};
				`ILE_R_RDATA:  prdata_ff <= {24'h0, rd_ff};
				`ILE_R_ISTAT:  prdata_ff <= {30'h0, stat_ff};
				`ILE_R_IMASK:  prdata_ff <= {30'h0, mask_ff};
				default:       prdata_ff <= 32'h00000000;
			endcase
		end else begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_ff <= 2'h0;
			mask_ff <= 2'h0;
			op_ff   <= `ILE_OP_WR;
			addr_ff <= 8'h00;
			wdat_ff <= 8'h00;
		end else if (apbDo && pwrite) begin
			if (paddr == `ILE_R_CTRL) ctrl_ff <= pwdata[1:0];
			if (paddr == `ILE_R_IMASK) mask_ff <= pwdata[1:0];
			if (cmdGo) begin
				addr_ff <= pwdata[7:0];
				op_ff   <= pwdata[18:16];
				// Protected positions always written as ones in the low latch byte
				wdat_ff <= pwdata[15:8] | ((pwdata[7:0] == `ILE_A_LAT_LO) ? `ILE_PROT_BITS : 8'h00); // see R3
			end
		end
	end

	// ----------------------------------------
	// Events, write one to clear, set wins
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			stat_ff <= 2'h0;
			irq_ff  <= 1'b0;
		end else begin
			stat_ff[`ILE_EV_ACC]  <= accEv || (stat_ff[`ILE_EV_ACC] &&
				!(apbDo && pwrite && paddr == `ILE_R_ISTAT && pwdata[`ILE_EV_ACC]));
			stat_ff[`ILE_EV_DONE] <= doneEv || (stat_ff[`ILE_EV_DONE] &&
				!(apbDo && pwrite && paddr == `ILE_R_ISTAT && pwdata[`ILE_EV_DONE]));
			irq_ff <= |(stat_ff & mask_ff);
		end
	end

	// ----------------------------------------
	// Command sequencer
	// ----------------------------------------
	// Guarded edits run master-off, plain load, then master-on again, except at the low enable address
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ILE_IDLE;
			rd_ff    <= 8'h00;
			vec_ff   <= 5'h00;
		end else begin
			unique case (state_ff)
				ILE_IDLE: begin
					if (cmdGo) begin
						state_ff <= (pwdata[18:16] == `ILE_OP_WR && ctrl_ff[1]) ? ILE_DIS : ILE_ACC; // see R7
					end else if (ctrl_ff[0] && sfr.intReq) begin
						state_ff <= ILE_ACK;
						vec_ff   <= sfr.intVec;
					end
				end
				ILE_DIS:  state_ff <= ILE_ACC;
				ILE_ACC:  state_ff <= (op_ff == `ILE_OP_RD) ? ILE_WAIT
					: (ctrl_ff[1] && op_ff == `ILE_OP_WR && isLatch) ? ILE_ENA : ILE_IDLE; // see R8
				ILE_WAIT: begin
					if (sfr.sfrRvalid) begin
						rd_ff    <= sfr.sfrRdata;
						state_ff <= ILE_IDLE;
					end
				end
				ILE_ENA:  state_ff <= ILE_IDLE;
				ILE_ACK:  state_ff <= ILE_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Unit drive, registered
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			{oWr_ff, oRd_ff, oAck_ff, oRet_ff, oEi_ff, oDi_ff} <= 6'h00;
			oAddr_ff <= 8'h00;
			oWd_ff   <= 8'h00;
		end else begin
			oAddr_ff <= addr_ff;
			oWd_ff   <= wdat_ff;
			oWr_ff   <= state_ff == ILE_ACC && op_ff == `ILE_OP_WR; // see R4
			oRd_ff   <= state_ff == ILE_ACC && op_ff == `ILE_OP_RD;
			oEi_ff   <= (state_ff == ILE_ACC && op_ff == `ILE_OP_EI) || state_ff == ILE_ENA;
			oDi_ff   <= (state_ff == ILE_ACC && op_ff == `ILE_OP_DI) || state_ff == ILE_DIS;
			oRet_ff  <= state_ff == ILE_ACC && op_ff == `ILE_OP_RET;
			oAck_ff  <= state_ff == ILE_IDLE && !cmdGo && ctrl_ff[0] && sfr.intReq;
		end
	end

	assign sfr.sfrAddr  = oAddr_ff;
	assign sfr.sfrWdata = oWd_ff;
	assign sfr.sfrWr    = oWr_ff;
	assign sfr.sfrRd    = oRd_ff;
	assign sfr.eiPulse  = oEi_ff;
	assign sfr.diPulse  = oDi_ff;
	assign sfr.retPulse = oRet_ff;
	assign sfr.intAck   = oAck_ff;
	assign prdata       = prdata_ff;
	assign pready       = pready_ff;
	assign pslverr      = pslverr_ff;
	assign irq          = irq_ff;

endmodule : ile_cpu_end

// [testbench/ile_properties.sv]
/*
 Concurrent checks on the SFR path, the acceptance handshake and the flag.
 Assumes one clock, an active-low asynchronous reset, and the unit's outputs.
*/
`timescale 1ns/1ps
`include "ile_params.svh"

module ile_properties (
	// Clock and reset
	input wire logic                 ref_clk,
	input wire logic                 arst_n,
	// Unit observation
	input wire logic [`ILE_NSRC-1:0] srcReq,
	input wire logic                 imfOut,
	input wire logic [`ILE_NSRC-1:0] latchOut,
	// Interface
	input wire logic [7:0]           sfrAddr,
	input wire logic                 sfrWr,
	input wire logic                 sfrRd,
	input wire logic [7:0]           sfrWdata,
	input wire logic [7:0]           sfrRdata,
	input wire logic                 sfrRvalid,
	input wire logic                 intReq,
	input wire logic [4:0]           intVec,
	input wire logic                 intAck,
	input wire logic                 retPulse,
	input wire logic                 eiPulse,
	input wire logic                 diPulse
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	// ----------------------------------------
	// Shadow of the flag stack
	// ----------------------------------------
	// Overflow is not modelled; nesting stays shallow in the bench
	logic [7:0] stk_ff;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			stk_ff <= 8'h00;
		else if (intAck && intReq)
			stk_ff <= {stk_ff[6:0], imfOut};
		else if (retPulse)
			stk_ff <= {1'b0, stk_ff[7:1]};
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence s_accept;
		intAck && intReq;
	endsequence
	sequence s_flag_off;
		!imfOut;
	endsequence

	property p_rd_answer; sfrRd |=> sfrRvalid; endproperty
	property p_rvalid_cause; sfrRvalid |-> $past(sfrRd); endproperty
	property p_latch_read;
		sfrRvalid && $past(sfrAddr) == `ILE_A_LAT_LO |-> sfrRdata == $past(latchOut[7:0]);
	endproperty
	property p_latch_write;
		sfrWr && sfrAddr == `ILE_A_LAT_LO && !intAck |=>
			latchOut[7:0] == ((($past(latchOut[7:0]) & $past(sfrWdata)) | $past(srcReq[7:0])) & 8'hfc);
	endproperty
	property p_no_spurious; (latchOut & ~$past(latchOut) & ~$past(srcReq)) == 24'h0; endproperty
	property p_accept; s_accept |=> s_flag_off; endproperty
	property p_masked; intReq && !imfOut |-> intVec == 5'd2 || intVec == 5'd3; endproperty
	property p_nmi_first;
		intReq && intVec > 5'd3 && $stable(latchOut[3:2]) |-> latchOut[3:2] == 2'b00;
	endproperty
	property p_imf_reset; $rose(arst_n) |-> !imfOut; endproperty
	property p_ei_di; eiPulse || diPulse |=> imfOut == $past(eiPulse); endproperty
	property p_return; retPulse |=> imfOut == $past(stk_ff[0]); endproperty

	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray read valid");
	a_latch_read: assert property (p_latch_read) else $error("latch read wrong");
	a_latch_write: assert property (p_latch_write) else $error("latch write wrong");
	a_no_spurious: assert property (p_no_spurious) else $error("latch set without event");
	a_accept: assert property (p_accept) else $error("flag kept on accept");
	a_masked: assert property (p_masked) else $error("maskable while flag low");
	a_nmi_first: assert property (p_nmi_first) else $error("priority wrong");
	a_imf_reset: assert property (p_imf_reset) else $error("flag set after reset");
	a_ei_di: assert property (p_ei_di) else $error("enable or disable missed");
	a_return: assert property (p_return) else $error("flag not restored");
endmodule : ile_properties

// [testbench/interrupt_latch_enable_unit_test.sv]
/*
 Bench for both ends joined by the SFR interface, driven over APB.
 Assumes the design files and the constants header are compiled first.
*/
`timescale 1ns/1ps
`include "ile_params.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module interrupt_latch_enable_unit_test
	import ile_pkg::*;
;
	logic        ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, imfOut, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v;
	logic [7:0]  b;
	ile_word_t   srcReq, latchOut;
	int          errors, n_checks;
	// Rows: SFR address, written byte, byte read back
	logic [23:0] rows [10] = '{24'h3af1f1, 24'h3ba5a5, 24'h2c5a5a, 24'h3a0000, 24'h3cff00,
		24'h3dff00, 24'h2eff00, 24'h40ff00, 24'h3b0000, 24'h2c0000};

	ile_sfr_if sfrBus ();
	ile_device i_ile_device (.ref_clk(ref_clk), .arst_n(arst_n), .srcReq(srcReq), .sfr(sfrBus),
		.imfOut(imfOut), .latchOut(latchOut));
	ile_cpu_end i_ile_cpu_end (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .sfr(sfrBus));
	ile_properties i_ile_properties (.ref_clk(ref_clk), .arst_n(arst_n), .srcReq(srcReq),
		.imfOut(imfOut), .latchOut(latchOut), .sfrAddr(sfrBus.sfrAddr), .sfrWr(sfrBus.sfrWr),
		.sfrRd(sfrBus.sfrRd), .sfrWdata(sfrBus.sfrWdata), .sfrRdata(sfrBus.sfrRdata),
		.sfrRvalid(sfrBus.sfrRvalid), .intReq(sfrBus.intReq), .intVec(sfrBus.intVec),
		.intAck(sfrBus.intAck), .retPulse(sfrBus.retPulse), .eiPulse(sfrBus.eiPulse),
		.diPulse(sfrBus.diPulse));

	always #20 ref_clk = ~ref_clk;

	// ----------------------------------------
	// Bus and command tasks
	// ----------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the slave
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Polls for completion, since a guarded write spans several unit cycles
	task automatic sfr(input logic [2:0] op, input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, `ILE_R_CMD, {13'h0, op, d, a}, v);
		do begin
			apb(1'b0, `ILE_R_ISTAT, 32'h0, v);
		end while (v[`ILE_EV_DONE] !== 1'b1);
		apb(1'b1, `ILE_R_ISTAT, 32'h2, v);
		apb(1'b0, `ILE_R_RDATA, 32'h0, v);
		b = v[7:0];
	endtask : sfr

	task automatic pulse(input ile_word_t m);
		@(posedge ref_clk);
		srcReq <= m;
		@(posedge ref_clk);
		srcReq <= 24'h0;
	endtask : pulse

	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	initial begin
		#(40 * 30000);
		errors++;
		print_verdict();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		srcReq = 24'h0;
		errors = 0;
		n_checks = 0;
		repeat (16) @(posedge ref_clk);
		arst_n <= 1'b1;
		sfr(`ILE_OP_RD, `ILE_A_EN_LO, 8'h00);
		`CHK(b, 8'h00)
		for (int i = 0; i < 10; i++) begin
			sfr(`ILE_OP_WR, rows[i][23:16], rows[i][15:8]);
			sfr(`ILE_OP_RD, rows[i][23:16], 8'h00);
			`CHK(b, rows[i][7:0])
		end
		apb(1'b0, 12'h020, 32'h0, v);
		`CHK(err, 1'b1)
		// Latches set by events, read back, one cleared alone while the other stays set
		pulse(24'h000220);
		sfr(`ILE_OP_RD, `ILE_A_LAT_LO, 8'h00);
		`CHK(b, 8'h20)
		sfr(`ILE_OP_WR, `ILE_A_LAT_LO, 8'h0c);
		sfr(`ILE_OP_RD, `ILE_A_LAT_HI, 8'h00);
		`CHK(b, 8'h02)
		`CHK(latchOut, 24'h000200)
		// Maskable source against master and source enables
		sfr(`ILE_OP_WR, `ILE_A_EN_HI, 8'h02);
		repeat (8) @(posedge ref_clk);
		`CHK(sfrBus.intReq, 1'b0)
		sfr(`ILE_OP_EI, 8'h00, 8'h00);
		for (int n = 0; n < 40 && sfrBus.intReq !== 1'b1; n++) @(posedge ref_clk);
		`CHK(sfrBus.intVec, 5'd9)
		sfr(`ILE_OP_DI, 8'h00, 8'h00);
		sfr(`ILE_OP_WR, `ILE_A_EN_HI, 8'h00);
		sfr(`ILE_OP_EI, 8'h00, 8'h00);
		repeat (8) @(posedge ref_clk);
		`CHK(sfrBus.intReq, 1'b0)
		sfr(`ILE_OP_DI, 8'h00, 8'h00);
		sfr(`ILE_OP_WR, `ILE_A_EN_HI, 8'h02);
		apb(1'b1, `ILE_R_IMASK, 32'h1, v);
		apb(1'b1, `ILE_R_CTRL, 32'h1, v);
		sfr(`ILE_OP_EI, 8'h00, 8'h00);
		for (int n = 0; n < 40 && irq !== 1'b1; n++) @(posedge ref_clk);
		`CHK(irq, 1'b1)
		`CHK(imfOut, 1'b0)
		`CHK(latchOut, 24'h000000)
		apb(1'b0, `ILE_R_STATUS, 32'h0, v);
		`CHK(v[12:8], 5'd9)
		apb(1'b1, `ILE_R_ISTAT, 32'h1, v);
		repeat (3) @(posedge ref_clk);
		`CHK(irq, 1'b0)
		sfr(`ILE_OP_RET, 8'h00, 8'h00);
		`CHK(imfOut, 1'b1)
		// Non-maskable pair with the flag low, then nested acceptance
		sfr(`ILE_OP_DI, 8'h00, 8'h00);
		apb(1'b1, `ILE_R_CTRL, 32'h0, v);
		apb(1'b1, `ILE_R_IMASK, 32'h0, v);
		pulse(24'h00000c);
		for (int n = 0; n < 40 && sfrBus.intReq !== 1'b1; n++) @(posedge ref_clk);
		`CHK(sfrBus.intVec, 5'd2)
		apb(1'b1, `ILE_R_CTRL, 32'h1, v);
		repeat (12) @(posedge ref_clk);
		`CHK(latchOut, 24'h000000)
		`CHK(irq, 1'b0)
		apb(1'b0, `ILE_R_STATUS, 32'h0, v);
		`CHK(v[12:8], 5'd3)
		sfr(`ILE_OP_RET, 8'h00, 8'h00);
		sfr(`ILE_OP_RET, 8'h00, 8'h00);
		`CHK(imfOut, 1'b0)
		// Guarded edit: master dropped around the load, raised again after it
		apb(1'b1, `ILE_R_CTRL, 32'h2, v);
		sfr(`ILE_OP_WR, `ILE_A_EN_TOP, 8'h01);
		`CHK(imfOut, 1'b1)
		sfr(`ILE_OP_RD, `ILE_A_EN_TOP, 8'h00);
		`CHK(b, 8'h01)
		// Reset in mid-run drops the master flag and the enables
		@(posedge ref_clk);
		arst_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		`CHK(imfOut, 1'b0)
		sfr(`ILE_OP_RD, `ILE_A_EN_TOP, 8'h00);
		`CHK(b, 8'h00)
		sfr(`ILE_OP_RD, `ILE_A_EN_LO, 8'h00);
		`CHK(b, 8'h00)
		print_verdict();
	end
endmodule : interrupt_latch_enable_unit_test
